// *** packet_buffer_self_test_bench.sv ***
// self-checking bench for the packet buffer self-test engine
`timescale 1ns/10ps
module packet_buffer_self_test_bench;
   import pbst_pkg::*;
   logic        sys_clk    = 1'b0;
   logic        reset_n    = 1'b0;
   logic        ctrl_wr    = 1'b0;
   logic        seed_wr    = 1'b0;
   pbst_byte_t  ctrl_wdata = 8'h00;
   pbst_byte_t  seed_wdata = 8'h00;
   logic [3:0]  dma_ctl    = 4'h0;   // set, clr, run done, flag clr
   logic        dma_rd     = 1'b0;
   pbst_addr_t  dma_addr   = 13'h0000;
   pbst_byte_t  ctl, seed, ckh, ckl, dma_rdata, a_wd, b_wd, a_rd, b_rd;
   pbst_addr_t  a_ad, b_ad;
   logic        dma_start, dma_done_flag, a_we, a_re, b_we, b_re;
   pbst_byte_t  exp_mem [0:8191];
   logic [31:0] rng = 32'h60;
   logic [15:0] ck;
   int          mismatches = 0;
   int          num_checks = 0;
   int          wa;

   always #5 sys_clk = ~sys_clk;

   pbst_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .seed_wr(seed_wr), .seed_wdata(seed_wdata), .self_test_control(ctl), .self_test_seed(seed),
      .self_test_checksum_high(ckh), .self_test_checksum_low(ckl), .dma_start_set(dma_ctl[0]),
      .dma_start_clr(dma_ctl[1]), .dma_run_done(dma_ctl[2]), .dma_flag_clr(dma_ctl[3]),
      .dma_start(dma_start), .dma_done_flag(dma_done_flag), .dma_rd(dma_rd), .dma_addr(dma_addr),
      .dma_rdata(dma_rdata), .mem_a_addr(a_ad), .mem_a_wdata(a_wd), .mem_a_we(a_we), .mem_a_re(a_re),
      .mem_a_rdata(a_rd), .mem_b_addr(b_ad), .mem_b_wdata(b_wd), .mem_b_we(b_we), .mem_b_re(b_re),
      .mem_b_rdata(b_rd));

   pbst_sram_model sram (.sys_clk(sys_clk), .a_addr(a_ad), .a_wdata(a_wd), .a_we(a_we), .a_re(a_re),
      .a_rdata(a_rd), .b_addr(b_ad), .b_wdata(b_wd), .b_we(b_we), .b_re(b_re), .b_rdata(b_rd));

   // ----------------------------------------------------------------
   // helpers: compare, drive, expected data
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // a wait that used up its bound is a failure: count it and stop at once
   task automatic bound_hit(input bit stuck, input string nm);
      if (stuck) begin
         mismatches++;
         $display("unexpected %s: expected done seen timeout", nm);
         wrap_up();
      end
   endtask

   // one-cycle strobe; both data buses carry the value, only the strobe selects
   task automatic reg_wr(input bit to_seed, input pbst_byte_t v);
      @(negedge sys_clk);
      ctrl_wr = !to_seed;
      seed_wr = to_seed;
      ctrl_wdata = v;
      seed_wdata = v;
      @(negedge sys_clk);
      ctrl_wr = 1'b0;
      seed_wr = 1'b0;
   endtask

   task automatic dma_pulse(input logic [3:0] v);
      @(negedge sys_clk);
      dma_ctl = v;
      @(negedge sys_clk);
      dma_ctl = 4'h0;
   endtask

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // end-around-carry add of one 16-bit word
   function automatic logic [15:0] fold(input logic [15:0] a, input logic [15:0] w);
      logic [16:0] s;
      s = a + w;
      return s[15:0] + 16'(s[16]);
   endfunction

   // fills exp_mem, returns final generator state and checksum
   task automatic gen(input logic [1:0] ft, input pbst_byte_t sd, input logic [2:0] sh,
                      output pbst_byte_t fin, output logic [15:0] cs);
      logic [15:0] acc;
      acc = 16'h0000;
      for (int i = 0; i < 8192; i++) begin
         case (ft)
            FILL_ADDRESS: exp_mem[i] = i[7:0];
            FILL_RESERVED: exp_mem[i] = 8'h00;
            default: exp_mem[i] = sd;
         endcase
         if (ft == FILL_RANDOM)
            sd = {sd[6:0], 1'b0} ^ (sd[7] ? LFSR_TAPS : 8'h00);
         if (ft == FILL_PATTERN)
            sd = (sd << sh) | (sd >> (4'h8 - sh));
         if (i[0])
            acc = fold(acc, {exp_mem[i - 1], exp_mem[i]});
      end
      fin = sd;
      cs = ~acc;
   endtask

   // configure, start, watch the write run, then check results
   task automatic run_fill(input logic [1:0] ft, input bit sw, input logic [2:0] sh, input pbst_byte_t sd);
      pbst_byte_t c, fin;
      int         wb, n;
      c = {sh, sw, ft, 2'b10};
      chk("dma idle", 16'h0, 16'(dma_start));
      gen(ft, sd, sh, fin, ck);
      if (ft != FILL_ADDRESS)
         reg_wr(1'b1, sd);
      reg_wr(1'b0, c);
      wa = sram.wr_a;
      wb = sram.wr_b;
      reg_wr(1'b0, c | 8'h01);
      n = 0;
      while ((a_we | b_we) !== 1'b1 && n < 10) begin
         @(negedge sys_clk);
         n++;
      end
      bound_hit((a_we | b_we) !== 1'b1, "fill start");
      chk("busy", 16'(c | 8'h01), 16'(ctl));
      n = 0;
      while ((a_we | b_we) === 1'b1 && n < 9000) begin
         seed_wr = (n == 50);   // poke is refused while filling
         seed_wdata = ~sd;
         @(negedge sys_clk);
         n++;
      end
      bound_hit((a_we | b_we) === 1'b1, "fill end");
      chk("write run", 16'h2000, 16'(n));
      n = 0;
      while (ctl[0] !== 1'b0 && n < 5) begin
         @(negedge sys_clk);
         n++;
      end
      bound_hit(ctl[0] !== 1'b0, "busy clear");
      chk("ctrl done", 16'(c), 16'(ctl));
      chk("cksum", ft == FILL_ADDRESS ? CKS_ADDR_FILL : ck, {ckh, ckl});
      chk("port a writes", sw ? 16'h0 : 16'h2000, 16'(sram.wr_a - wa));
      chk("port b writes", sw ? 16'h2000 : 16'h0, 16'(sram.wr_b - wb));
      if (ft == FILL_RANDOM)
         chk("seed final", 16'(fin), 16'(seed));
      n = 0;
      for (int i = 0; i < 8192; i++)
         n += int'(sram.mem[i] !== exp_mem[i]);
      chk("contents", 16'h0, 16'(n));
   endtask

   // streams all bytes through the DMA port, three cycles of latency
   task automatic dma_check(input logic [15:0] e);
      logic [15:0] acc;
      pbst_byte_t  hi;
      acc = 16'h0000;
      hi = 8'h00;
      dma_pulse(4'h1);
      chk("dma start", 16'h1, 16'(dma_start));
      for (int i = 0; i < 8195; i++) begin
         @(negedge sys_clk);
         if (i >= 3 && i[0])
            hi = dma_rdata;
         else if (i >= 3)
            acc = fold(acc, {hi, dma_rdata});
         dma_rd = (i < 8192);
         dma_addr = 13'(i);
      end
      chk("dma cksum", e, ~acc);
      dma_pulse(4'hC);
      chk("dma start done", 16'h0, 16'(dma_start));
      chk("dma flag", 16'h1, 16'(dma_done_flag));
      dma_pulse(4'h8);
      chk("dma flag clr", 16'h0, 16'(dma_done_flag));
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      chk("reset ctrl", 16'(CTRL_RESET), 16'(ctl));
      chk("reset cksum", 16'h0000, {ckh, ckl});
      chk("reset dma", 16'h0, 16'({dma_start, dma_done_flag, a_we, b_we}));
      // start without test enable must stay idle
      reg_wr(1'b0, 8'h01);
      repeat (3) @(negedge sys_clk);
      chk("no enable", 16'h0, 16'({ctl, a_we, b_we}));
      run_fill(FILL_ADDRESS, 1'b0, 3'h5, 8'h00);
      dma_check(CKS_ADDR_FILL);
      // cancel in mid-fill
      reg_wr(1'b0, 8'h06);
      reg_wr(1'b0, 8'h07);
      repeat (100) @(negedge sys_clk);
      dma_pulse(4'h1);
      reg_wr(1'b0, 8'h00);
      wa = sram.wr_a;   // last beat lands on the cancelling edge
      dma_pulse(4'h2);
      repeat (20) @(negedge sys_clk);
      chk("abort writes", 16'h0, 16'(sram.wr_a - wa));
      chk("abort state", 16'h0, 16'({ctl, dma_start}));
      chk("abort cksum", CKS_ADDR_FILL, {ckh, ckl});
      rng = xs(rng);
      run_fill(FILL_RANDOM, 1'b1, rng[10:8] | 3'h1, rng[7:0] | 8'h01);
      dma_check(ck);
      run_fill(FILL_RANDOM, 1'b0, 3'h0, 8'h00);
      rng = xs(rng);
      run_fill(FILL_PATTERN, 1'b0, rng[10:8], rng[7:0]);
      run_fill(FILL_PATTERN, 1'b1, 3'h7, 8'h81);
      rng = xs(rng);
      run_fill(FILL_RESERVED, 1'b0, 3'h2, rng[7:0]);
      wrap_up();
   end
endmodule

// *** pbst_cks_if.sv ***
// link between the fill engine and its checksum accumulator
`timescale 1ns/10ps
interface pbst_cks_if;
   logic        clr;
   logic        byte_vld;
   logic [7:0]  byte_data;
   logic [15:0] result;

   modport eng (output clr, output byte_vld, output byte_data, input result);
   modport acc (input clr, input byte_vld, input byte_data, output result);
endinterface

// *** pbst_cksum.sv ***
// ones'-complement checksum accumulator for the fill engine
`timescale 1ns/10ps
module pbst_cksum (
   input  wire logic   sys_clk,
   input  wire logic   reset_n,
   pbst_cks_if.acc     cks
);
   import pbst_pkg::*;

   logic [15:0] sum_r;
   logic [7:0]  hi_r;
   logic        odd_r;
   logic [16:0] add_full;

   // even bytes are the high half of each word, odd bytes the low half
   assign add_full = {1'b0, sum_r} + {1'b0, hi_r, cks.byte_data};

   // ----------------------------------------------------------------
   // accumulate with end-around carry
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sum_r <= 16'h0000;
         hi_r  <= 8'h00;
         odd_r <= 1'b0;
      end else if (cks.clr) begin
         sum_r <= 16'h0000;
         hi_r  <= 8'h00;
         odd_r <= 1'b0;
      end else if (cks.byte_vld) begin
         if (odd_r) begin
            sum_r <= add_full[15:0] + {15'h0000, add_full[16]};
         end else begin
            hi_r <= cks.byte_data;
         end
         odd_r <= ~odd_r;
      end
   end

   // complement of the folded sum, as the DMA engine reports it
   assign cks.result = ~sum_r;
endmodule

// *** pbst_pkg.sv ***
// shared constants and types of the packet buffer self-test engine
// Functional notes
// - engine fills all 8 Kbytes, summing each byte
// - finished sum loads both checksum registers
// - bit 0 start/busy, hardware clears when done
// - bit 1 test enable gates any start
// - bits 3-2 pick random, address, pattern fill
// - bit 4 swaps engine and DMA ports
// - bits 7-5 rotate seed, pattern fill only
// - pattern fill: seed first, rotate before each next
// - random fill from seeded LFSR, final state kept
// - zero seed gives all-zero random data
// - address fill writes address low byte
// - full address fill sums to F807h
// - one byte written per clock cycle
// - clearing start or enable cancels test; DMA start has no effect
// - DMA done clears start, sets done flag
package pbst_pkg;
   typedef logic [7:0]  pbst_byte_t;
   typedef logic [12:0] pbst_addr_t;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int          CTRL_BUSY_BIT  = 0;
   localparam int          CTRL_TME_BIT   = 1;
   localparam int          CTRL_FILL_LSB  = 2;
   localparam int          CTRL_SWAP_BIT  = 4;
   localparam int          CTRL_SHIFT_LSB = 5;
   localparam pbst_byte_t  CTRL_RESET     = 8'h00;
   localparam pbst_byte_t  SEED_RESET     = 8'h00;
   localparam pbst_byte_t  CKS_RESET      = 8'h00;

   // fill type codes
   localparam logic [1:0]  FILL_RANDOM    = 2'h0;
   localparam logic [1:0]  FILL_ADDRESS   = 2'h1;
   localparam logic [1:0]  FILL_PATTERN   = 2'h2;
   localparam logic [1:0]  FILL_RESERVED  = 2'h3;

   // ----------------------------------------------------------------
   // buffer and generator constants
   // ----------------------------------------------------------------
   localparam pbst_addr_t  BUF_FIRST      = 13'h0000;
   localparam pbst_addr_t  BUF_LAST       = 13'h1FFF;
   localparam pbst_byte_t  LFSR_TAPS      = 8'h1D;   // x^8+x^4+x^3+x^2+1
   localparam logic [15:0] CKS_ADDR_FILL  = 16'hF807;

   typedef enum logic [1:0] {
      PBST_IDLE = 2'b00,
      PBST_FILL = 2'b01,
      PBST_DONE = 2'b10
   } pbst_state_t;
endpackage

// *** pbst_sram_model.sv ***
// dual-port packet buffer model with per-port write counters
`timescale 1ns/10ps
module pbst_sram_model (
   input  wire logic        sys_clk,
   input  wire logic [12:0] a_addr,
   input  wire logic [7:0]  a_wdata,
   input  wire logic        a_we,
   input  wire logic        a_re,
   output logic [7:0]       a_rdata,
   input  wire logic [12:0] b_addr,
   input  wire logic [7:0]  b_wdata,
   input  wire logic        b_we,
   input  wire logic        b_re,
   output logic [7:0]       b_rdata
);
   logic [7:0] mem [0:8191];
   int         wr_a = 0;
   int         wr_b = 0;

   initial begin
      a_rdata = 8'h00;
      b_rdata = 8'h00;
   end

   // port a: registered read, idle port inverts so stale bytes never match
   always @(posedge sys_clk) begin
      if (a_we) begin
         mem[a_addr] <= a_wdata;
         wr_a <= wr_a + 1;
      end
      a_rdata <= a_re ? mem[a_addr] : ~a_rdata;
   end

   // port b: same behaviour as port a
   always @(posedge sys_clk) begin
      if (b_we) begin
         mem[b_addr] <= b_wdata;
         wr_b <= wr_b + 1;
      end
      b_rdata <= b_re ? mem[b_addr] : ~b_rdata;
   end
endmodule

// *** pbst_top.sv ***
// packet buffer self-test engine with port swap and DMA status bits
`timescale 1ns/10ps
module pbst_top (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // host register access
   input  wire logic              ctrl_wr,
   input  wire pbst_pkg::pbst_byte_t ctrl_wdata,
   input  wire logic              seed_wr,
   input  wire pbst_pkg::pbst_byte_t seed_wdata,
   output pbst_pkg::pbst_byte_t   self_test_control,
   output pbst_pkg::pbst_byte_t   self_test_seed,
   output pbst_pkg::pbst_byte_t   self_test_checksum_high,
   output pbst_pkg::pbst_byte_t   self_test_checksum_low,
   // DMA start bit and done flag
   input  wire logic              dma_start_set,
   input  wire logic              dma_start_clr,
   input  wire logic              dma_run_done,
   input  wire logic              dma_flag_clr,
   output logic                   dma_start,
   output logic                   dma_done_flag,
   // DMA engine read request
   input  wire logic              dma_rd,
   input  wire pbst_pkg::pbst_addr_t dma_addr,
   output pbst_pkg::pbst_byte_t   dma_rdata,
   // dual-port buffer, port A and port B
   output pbst_pkg::pbst_addr_t   mem_a_addr,
   output pbst_pkg::pbst_byte_t   mem_a_wdata,
   output logic                   mem_a_we,
   output logic                   mem_a_re,
   input  wire pbst_pkg::pbst_byte_t mem_a_rdata,
   output pbst_pkg::pbst_addr_t   mem_b_addr,
   output pbst_pkg::pbst_byte_t   mem_b_wdata,
   output logic                   mem_b_we,
   output logic                   mem_b_re,
   input  wire pbst_pkg::pbst_byte_t mem_b_rdata
);
   import pbst_pkg::*;

   pbst_state_t  state_r;
   pbst_byte_t   ctrl_r;
   pbst_byte_t   seed_r;
   pbst_byte_t   seed_nxt;
   pbst_byte_t   fill_byte;
   pbst_addr_t   addr_r;
   pbst_byte_t   cks_hi_r;
   pbst_byte_t   cks_lo_r;
   logic         dma_start_r;
   logic         dma_flag_r;
   logic         start_req;
   logic         abort_req;
   logic         filling;
   logic         eng_we_r;
   pbst_addr_t   eng_addr_r;
   pbst_byte_t   eng_data_r;
   logic         port_swap;
   logic [1:0]   fill_type;
   logic [2:0]   shift_amount;

   pbst_cks_if cks_bus ();

   assign fill_type    = ctrl_r[CTRL_FILL_LSB +: 2];
   assign shift_amount = ctrl_r[CTRL_SHIFT_LSB +: 3];
   assign port_swap    = ctrl_r[CTRL_SWAP_BIT];

   // rotate left, top bits wrap into the bottom
   function automatic pbst_byte_t rotl(input pbst_byte_t v, input logic [2:0] n);
      logic [15:0] dbl;
      dbl = {v, v} << n;
      return dbl[15:8];
   endfunction

   // ----------------------------------------------------------------
   // start and cancel decode
   // ----------------------------------------------------------------
   // a start only counts while enabled; a write dropping busy or enable aborts
   assign start_req = ctrl_wr && ctrl_wdata[CTRL_BUSY_BIT] && ctrl_wdata[CTRL_TME_BIT]
                      && (state_r == PBST_IDLE);
   assign abort_req = ctrl_wr && (!ctrl_wdata[CTRL_BUSY_BIT] || !ctrl_wdata[CTRL_TME_BIT]);
   assign filling   = (state_r == PBST_FILL) && !abort_req;

   // ----------------------------------------------------------------
   // fill data generation
   // ----------------------------------------------------------------
   always_comb begin
      fill_byte = seed_r;
      seed_nxt  = seed_r;
      unique case (fill_type)
         FILL_RANDOM: begin
            fill_byte = seed_r;
            // galois step; zero is a fixed point so zero seed stays zero
            seed_nxt  = {seed_r[6:0], 1'b0} ^ (seed_r[7] ? LFSR_TAPS : 8'h00);
         end
         FILL_ADDRESS: begin
            fill_byte = addr_r[7:0];
            seed_nxt  = seed_r;
         end
         FILL_PATTERN: begin
            fill_byte = seed_r;
            seed_nxt  = rotl(seed_r, shift_amount);
         end
         FILL_RESERVED: begin
            // reserved code writes zeros so the checksum stays predictable
            fill_byte = 8'h00;
            seed_nxt  = seed_r;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= PBST_IDLE;
         addr_r  <= BUF_FIRST;
      end else begin
         unique case (state_r)
            PBST_IDLE: begin
               addr_r <= BUF_FIRST;
               if (start_req) begin
                  state_r <= PBST_FILL;
               end
            end
            PBST_FILL: begin
               if (abort_req) begin
                  state_r <= PBST_IDLE;
               end else if (addr_r == BUF_LAST) begin
                  state_r <= PBST_DONE;
               end else begin
                  addr_r <= addr_r + 13'h0001;
               end
            end
            PBST_DONE: begin
               state_r <= PBST_IDLE;
            end
            default: begin
               state_r <= PBST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control register: host writes, hardware clears busy at the end
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_wdata;
         // busy only sticks when test mode is also on
         ctrl_r[CTRL_BUSY_BIT] <= start_req || (ctrl_wdata[CTRL_BUSY_BIT] && ctrl_wdata[CTRL_TME_BIT]
                                               && state_r == PBST_FILL);
      end else if (state_r == PBST_DONE) begin
         ctrl_r[CTRL_BUSY_BIT] <= 1'b0;
      end
   end

   // seed register: host value, advanced once per byte while filling
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         seed_r <= SEED_RESET;
      end else if (filling) begin
         seed_r <= seed_nxt;
      end else if (seed_wr) begin
         seed_r <= seed_wdata;
      end
   end

   // ----------------------------------------------------------------
   // checksum accumulation and capture
   // ----------------------------------------------------------------
   assign cks_bus.clr       = start_req;
   assign cks_bus.byte_vld  = filling;
   assign cks_bus.byte_data = fill_byte;

   pbst_cksum u_cksum (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .cks     (cks_bus)
   );

   // last byte is folded in by the done cycle, so capture then
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cks_hi_r <= CKS_RESET;
         cks_lo_r <= CKS_RESET;
      end else if (state_r == PBST_DONE) begin
         cks_hi_r <= cks_bus.result[15:8];
         cks_lo_r <= cks_bus.result[7:0];
      end
   end

   // ----------------------------------------------------------------
   // DMA start bit and done flag
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_start_r <= 1'b0;
      end else if (dma_run_done || dma_start_clr) begin
         dma_start_r <= 1'b0;
      end else if (dma_start_set) begin
         dma_start_r <= 1'b1;
      end
   end

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_flag_r <= 1'b0;
      end else if (dma_run_done) begin
         dma_flag_r <= 1'b1;
      end else if (dma_flag_clr) begin
         dma_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // engine write beat and port routing
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         eng_we_r   <= 1'b0;
         eng_addr_r <= BUF_FIRST;
         eng_data_r <= 8'h00;
      end else begin
         eng_we_r   <= filling;
         eng_addr_r <= addr_r;
         eng_data_r <= fill_byte;
      end
   end

   // swap lets both SRAM ports see writes and reads across two runs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_a_addr  <= BUF_FIRST;
         mem_a_wdata <= 8'h00;
         mem_a_we    <= 1'b0;
         mem_a_re    <= 1'b0;
         mem_b_addr  <= BUF_FIRST;
         mem_b_wdata <= 8'h00;
         mem_b_we    <= 1'b0;
         mem_b_re    <= 1'b0;
      end else begin
         mem_a_addr  <= port_swap ? dma_addr : addr_r;
         mem_a_wdata <= fill_byte;
         mem_a_we    <= !port_swap && filling;
         mem_a_re    <= port_swap && dma_rd;
         mem_b_addr  <= port_swap ? addr_r : dma_addr;
         mem_b_wdata <= fill_byte;
         mem_b_we    <= port_swap && filling;
         mem_b_re    <= !port_swap && dma_rd;
      end
   end

   // read data follows the DMA engine's port
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_rdata <= 8'h00;
      end else begin
         dma_rdata <= port_swap ? mem_a_rdata : mem_b_rdata;
      end
   end

   // register read-back
   assign self_test_control       = ctrl_r;
   assign self_test_seed          = seed_r;
   assign self_test_checksum_high = cks_hi_r;
   assign self_test_checksum_low  = cks_lo_r;
   assign dma_start               = dma_start_r;
   assign dma_done_flag           = dma_flag_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   property p_start_busy;
      start_req |=> self_test_control[CTRL_BUSY_BIT] && state_r == PBST_FILL && addr_r == BUF_FIRST;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

   property p_done_clear;
      state_r == PBST_DONE && !ctrl_wr |=> !self_test_control[CTRL_BUSY_BIT] && state_r == PBST_IDLE;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("busy not cleared at end");

   property p_cks_load;
      state_r == PBST_DONE |=> {self_test_checksum_high, self_test_checksum_low} == $past(cks_bus.result);
   endproperty
   a_cks_load: assert property (p_cks_load) else $error("checksum not loaded");

   property p_byte_rate;
      filling && addr_r != BUF_LAST |=> eng_we_r ##0 (filling || abort_req) && addr_r == $past(addr_r) + 13'h0001;
   endproperty
   a_byte_rate: assert property (p_byte_rate) else $error("fill did not advance one byte per cycle");

   // checked on the port itself, so a routing slip cannot hide behind the shadow beat
   property p_addr_data;
      (mem_a_we || mem_b_we) && fill_type == FILL_ADDRESS
         |-> mem_a_wdata == (mem_a_we ? mem_a_addr[7:0] : mem_b_addr[7:0]);
   endproperty
   a_addr_data: assert property (p_addr_data) else $error("address fill wrote wrong byte");

   property p_zero_seed;
      filling && fill_type == FILL_RANDOM && seed_r == 8'h00 |=> seed_r == 8'h00 && eng_data_r == 8'h00;
   endproperty
   a_zero_seed: assert property (p_zero_seed) else $error("zero seed left zero state");

   property p_pattern;
      filling && fill_type == FILL_PATTERN |=> seed_r == rotl($past(seed_r), $past(shift_amount))
                                              && eng_data_r == $past(seed_r);
   endproperty
   a_pattern: assert property (p_pattern) else $error("pattern rotation wrong");

   property p_swap;
      eng_we_r |-> ($past(port_swap) ? (mem_b_we && !mem_a_we && mem_b_addr == eng_addr_r)
                                     : (mem_a_we && !mem_b_we && mem_a_addr == eng_addr_r));
   endproperty
   a_swap: assert property (p_swap) else $error("engine on wrong port");

   property p_dma_done;
      dma_run_done |=> !dma_start && dma_done_flag;
   endproperty
   a_dma_done: assert property (p_dma_done) else $error("DMA completion not reflected");

   property p_abort;
      state_r == PBST_FILL && abort_req |=> state_r == PBST_IDLE && !eng_we_r ##1 !eng_we_r;
   endproperty
   a_abort: assert property (p_abort) else $error("cancel did not stop fill");
endmodule
